// File: ptenc_consts.svh
// constants for the tap encoder and nonvolatile timing block
`ifndef PTENC_CONSTS_SVH
`define PTENC_CONSTS_SVH
`define PTENC_CLK_MHZ 200
`define PTENC_TAP_MAX 8'h63
`define PTENC_BLK1_BASE 8'h19
`define PTENC_BLK2_BASE 8'h32
`define PTENC_BLK3_BASE 8'h4B
`define PTENC_BLK1_SUM 8'h51
`define PTENC_BLK2_ADD 8'h0E
`define PTENC_BLK3_SUM 8'hC3
`define PTENC_CLAMP_LOW 8'h00
`define PTENC_CLAMP_HIGH 8'h60
`define PTENC_NVW_TYP_MS 5
`define PTENC_NVW_MAX_MS 10
`define PTENC_PU_MIN_MS 25
`define PTENC_PU_TYP_MS 50
`define PTENC_PU_MAX_MS 75
`define PTENC_SETTLE_MAX_US 200
`define PTENC_US_CYCLES (`PTENC_CLK_MHZ)
`define PTENC_NVW_CYCLES (`PTENC_NVW_TYP_MS * 1000 * `PTENC_US_CYCLES)
`define PTENC_PU_CYCLES (`PTENC_PU_TYP_MS * 1000 * `PTENC_US_CYCLES)
`define PTENC_SETTLE_CYCLES (`PTENC_SETTLE_MAX_US * `PTENC_US_CYCLES)
`define PTENC_SETTLE_CYCLES_MAX 32'd39999
`endif

// File: ptenc_encoder.sv
// combinational tap position to wiper code encoder
`timescale 1ns/1ps
`include "ptenc_consts.svh"
module ptenc_encoder (
  ptenc_tap_if.enc tap
);
  logic [7:0] pos;

  assign pos = tap.tapReq[7:0];

  always_comb begin
    if (tap.tapReq < 0) begin
      tap.code = `PTENC_CLAMP_LOW;
    end else if (tap.tapReq > $signed({1'b0, `PTENC_TAP_MAX})) begin
      tap.code = tap.clampEn ? `PTENC_CLAMP_HIGH : `PTENC_CLAMP_LOW;
    end else if (pos >= `PTENC_BLK3_BASE) begin
      tap.code = 8'(`PTENC_BLK3_SUM - pos);
    end else if (pos >= `PTENC_BLK2_BASE) begin
      tap.code = 8'(`PTENC_BLK2_ADD + pos);
    end else if (pos >= `PTENC_BLK1_BASE) begin
      tap.code = 8'(`PTENC_BLK1_SUM - pos);
    end else begin
      tap.code = pos;
    end
  end
endmodule

// File: ptenc_host_model.sv
// bus master model: issues the stop that ends a write, then polls acknowledge
`timescale 1ns/1ps
module ptenc_host_model (
  input wire logic clk_sys,
  input wire logic go,
  input wire logic addrAckEnable,
  output logic nvWriteStop,
  output int polls
);
  initial begin
    nvWriteStop = 1'b0;
    polls = 0;
  end
  // =====
  // stop issue; kept apart from polling so a stop can land while busy
  always @(posedge go) begin
    @(posedge clk_sys);
    #1 nvWriteStop = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 nvWriteStop = 1'b0;
  end
  // acknowledge polling: count refused polls since the last stop
  always @(posedge clk_sys) begin
    #1;
    if (nvWriteStop) begin
      polls = 0;
    end else if (addrAckEnable !== 1'b1 && polls < 100) begin
      polls++;
    end
  end
endmodule

// File: ptenc_pkg.sv
// types for the tap encoder and nonvolatile timing block
package ptenc_pkg;
  typedef enum logic [1:0] {PTENC_POWERUP, PTENC_IDLE, PTENC_NVWRITE} ptenc_state_t;
  typedef logic [7:0] ptenc_code_t;
endpackage

// File: ptenc_tap_if.sv
// carries the tap request and encoded wiper code between encoder and top
`timescale 1ns/1ps
interface ptenc_tap_if;
  logic signed [8:0] tapReq;
  logic clampEn;
  ptenc_pkg::ptenc_code_t code;
  modport enc (input tapReq, input clampEn, output code);
  modport user (output tapReq, output clampEn, input code);
endinterface

// File: ptenc_top.sv
// tap encoder with nonvolatile write and power-up recall timing
`timescale 1ns/1ps
`include "ptenc_consts.svh"
module ptenc_top #(
  parameter int NVW_CYCLES = `PTENC_NVW_CYCLES,
  parameter int PU_CYCLES = `PTENC_PU_CYCLES,
  parameter int SETTLE_CYCLES = `PTENC_SETTLE_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic signed [8:0] tapReq,
  input wire logic clampEn,
  input wire logic wiperWrite,
  input wire logic nvWriteStop,
  input wire logic [7:0] storedCode,
  output logic [7:0] wiperCode,
  output logic [7:0] wiperRegister,
  output logic addrAckEnable,
  output logic nvWriteBusy,
  output logic recallDone
);
  ptenc_tap_if tap ();
  ptenc_pkg::ptenc_state_t state;
  logic [31:0] timer;
  logic [31:0] settleCount;
  logic settlePending;
  logic writeSync1;
  logic writeSync;
  logic stopSync1;
  logic stopSync;
  logic stopPrev;

  assign tap.tapReq = tapReq;
  assign tap.clampEn = clampEn;

  ptenc_encoder encoder (
    .tap(tap)
  );

  // ==========================================================
  // pin synchronisers; stop is edge detected only after the second stage
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      writeSync1 <= 1'b0;
      writeSync <= 1'b0;
      stopSync1 <= 1'b0;
      stopSync <= 1'b0;
      stopPrev <= 1'b0;
    end else begin
      writeSync1 <= wiperWrite;
      writeSync <= writeSync1;
      stopSync1 <= nvWriteStop;
      stopSync <= stopSync1;
      stopPrev <= stopSync;
    end
  end

  // ==========================================================
  // sequencer: power-up recall, then idle, then timed writes
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state <= ptenc_pkg::PTENC_POWERUP;
      timer <= 32'h0;
    end else begin
      case (state)
        ptenc_pkg::PTENC_POWERUP: begin
          if (timer == 32'(PU_CYCLES - 1)) begin
            state <= ptenc_pkg::PTENC_IDLE;
            timer <= 32'h0;
          end else begin
            timer <= timer + 32'h1;
          end
        end
        ptenc_pkg::PTENC_IDLE: begin
          if (stopSync && !stopPrev) begin
            state <= ptenc_pkg::PTENC_NVWRITE;
            timer <= 32'h0;
          end
        end
        ptenc_pkg::PTENC_NVWRITE: begin
          if (timer == 32'(NVW_CYCLES - 1)) begin
            state <= ptenc_pkg::PTENC_IDLE;
            timer <= 32'h0;
          end else begin
            timer <= timer + 32'h1;
          end
        end
        default: begin
          state <= ptenc_pkg::PTENC_POWERUP;
          timer <= 32'h0;
        end
      endcase
    end
  end

  assign nvWriteBusy = (state == ptenc_pkg::PTENC_NVWRITE);
  // a busy device stays silent so the master can poll for completion
  assign addrAckEnable = (state == ptenc_pkg::PTENC_IDLE);
  assign recallDone = (state != ptenc_pkg::PTENC_POWERUP);

  // ==========================================================
  // wiper register and delayed wiper update
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      wiperRegister <= 8'h00;
    end else if (state == ptenc_pkg::PTENC_POWERUP && timer == 32'(PU_CYCLES - 1)) begin
      wiperRegister <= storedCode;
    end else if (writeSync && recallDone) begin
      wiperRegister <= tap.code;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      wiperCode <= 8'h00;
      settlePending <= 1'b0;
      settleCount <= 32'h0;
    end else if (wiperCode != wiperRegister && !settlePending) begin
      settlePending <= 1'b1;
      settleCount <= 32'h0;
    end else if (settlePending) begin
      if (settleCount >= 32'(SETTLE_CYCLES - 1)) begin
        wiperCode <= wiperRegister;
        settlePending <= 1'b0;
      end else begin
        settleCount <= settleCount + 32'h1;
      end
    end
  end

  // ==========================================================
  // checks
  nv_write_len_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    $rose(nvWriteBusy) |-> nvWriteBusy [*8]) else $error("write ended early");
  stop_starts_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (state == ptenc_pkg::PTENC_IDLE && stopSync && !stopPrev) |=> nvWriteBusy)
    else $error("stop did not start write");
  busy_noack_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    nvWriteBusy |-> !addrAckEnable) else $error("ack during write");
  recall_wait_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (timer < 32'(PU_CYCLES - 1) && !recallDone) |=> !recallDone)
    else $error("recall too soon");
  settle_bound_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    settlePending |-> settleCount <= 32'(SETTLE_CYCLES)) else $error("wiper late");
  enc_low_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (tapReq >= 0 && tapReq < 25) |-> tap.code == tapReq[7:0]) else $error("low map");
  enc_mid_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (tapReq >= 25 && tapReq < 50) |-> tap.code == 8'(8'h51 - tapReq[7:0]))
    else $error("second map");
  enc_third_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (tapReq >= 50 && tapReq < 75) |-> tap.code == 8'(8'h0E + tapReq[7:0]))
    else $error("third map");
  enc_top_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (tapReq >= 75 && tapReq < 100) |-> tap.code == 8'(8'hC3 - tapReq[7:0]))
    else $error("top map");
  enc_clamp_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (tapReq > 99 && clampEn) |-> tap.code == 8'h60) else $error("clamp");
  enc_neg_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (tapReq < 0) |-> tap.code == 8'h00) else $error("negative clamp");
endmodule

// File: tb_pot_tap_encoder_nv_timing.sv
// self-checking bench for the tap encoder and nonvolatile timing block
`timescale 1ns/1ps
`define CHK(nm, e, a) begin n_compared++; if ((a) !== (e)) begin fails++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, a); end end
module tb_pot_tap_encoder_nv_timing;
  logic clk_sys = 1'b0, rst_b = 1'b0, clampEn = 1'b0, wiperWrite = 1'b0, go = 1'b0;
  logic signed [8:0] tapReq = '0;
  logic [7:0] storedCode = 8'h5A;
  logic [7:0] wiperCode, wiperRegister;
  logic addrAckEnable, nvWriteBusy, recallDone, nvWriteStop;
  int fails = 0, n_compared = 0, cyc = 0, polls, n;
  always #2.5 clk_sys = ~clk_sys;
  ptenc_top #(.NVW_CYCLES(20), .PU_CYCLES(30), .SETTLE_CYCLES(10)) i_dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .tapReq(tapReq), .clampEn(clampEn),
    .wiperWrite(wiperWrite), .nvWriteStop(nvWriteStop), .storedCode(storedCode),
    .wiperCode(wiperCode), .wiperRegister(wiperRegister), .addrAckEnable(addrAckEnable),
    .nvWriteBusy(nvWriteBusy), .recallDone(recallDone));
  ptenc_host_model i_host (.clk_sys(clk_sys), .go(go), .addrAckEnable(addrAckEnable),
    .nvWriteStop(nvWriteStop), .polls(polls));
  // =====
  // helpers
  function automatic logic [7:0] enc(int t, bit c);
    if (t < 0) return 8'h00;
    if (t > 99) return c ? 8'h60 : 8'h00;
    if (t > 74) return 8'(195 - t);
    if (t > 49) return 8'(14 + t);
    if (t > 24) return 8'(81 - t);
    return 8'(t);
  endfunction
  task automatic wr(int t, bit c);
    logic [7:0] e;
    e = enc(t, c);
    tapReq = 9'(t);
    clampEn = c;
    wiperWrite = 1'b1;
    repeat (4) @(posedge clk_sys);
    #1 wiperWrite = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 `CHK("wiperRegister", e, wiperRegister)
    n = 0;
    while (wiperCode !== e && n < 16) begin
      @(posedge clk_sys);
      #1 n++;
    end
    `CHK("wiperCode", e, wiperCode)
  endtask
  // =====
  // scenarios
  task automatic t_recall();
    // a write before recall must be dropped
    tapReq = 9'sh01E;
    wiperWrite = 1'b1;
    repeat (4) @(posedge clk_sys);
    #1 wiperWrite = 1'b0;
    `CHK("earlyWrite", 8'h00, wiperRegister)
    n = 0;
    while (recallDone !== 1'b1 && n < 60) begin
      @(posedge clk_sys);
      #1 n++;
    end
    `CHK("recallLate", 1'b1, n >= 20 && n <= 40)
    `CHK("recallCode", storedCode, wiperRegister)
  endtask
  task automatic t_map();
    for (int t = -2; t <= 101; t++) wr(t, 1'b1);
    wr(100, 1'b0);
  endtask
  task automatic t_nvwrite();
    go = 1'b1;
    @(posedge clk_sys);
    #1 go = 1'b0;
    repeat (5) @(posedge clk_sys);
    #1 `CHK("busy", 1'b1, nvWriteBusy)
    `CHK("ackOff", 1'b0, addrAckEnable)
    go = 1'b1; // a stop while busy must not stretch the cycle
    repeat (30) @(posedge clk_sys);
    #1 go = 1'b0;
    `CHK("polls", 1'b1, polls >= 13 && polls <= 19)
    `CHK("idle", 1'b0, nvWriteBusy)
  endtask
  task end_sim();
    if (fails == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc > 6000) begin
      fails++;
      end_sim();
    end
  end
  initial begin
    repeat (3) @(posedge clk_sys);
    #1 rst_b = 1'b1;
    t_recall();
    t_map();
    t_nvwrite();
    end_sim();
  end
endmodule
